// >>> include/dzmc_pkg.sv
/*
  Shared constants and types for the distance zone mode controller.
  Assumes a 100 MHz clock and one distance sample stream in millimetres.
*/
package dzmc_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned DIST_W         = 16;
  localparam int unsigned MODE_W         = 3;
  localparam int unsigned DELAY_MS       = 2000;
  localparam int unsigned TIMEOUT_S      = 30;
  localparam int unsigned HOLD_MS        = 1000;
  localparam int unsigned MS_CYCLES      = CLK_HZ / 1000;
  localparam int unsigned TICK_W         = 17;
  localparam int unsigned MS_CNT_W       = 16;
  localparam int unsigned DELAY_MS_DEF   = DELAY_MS;
  localparam int unsigned TIMEOUT_MS_DEF = TIMEOUT_S * 1000;
  localparam int unsigned HOLD_MS_DEF    = HOLD_MS;
  localparam logic [MODE_W-1:0] MODE_ONE   = 3'h1;
  localparam logic [MODE_W-1:0] MODE_TWO   = 3'h2;
  localparam logic [MODE_W-1:0] MODE_THREE = 3'h3;
  localparam logic [MODE_W-1:0] MODE_FOUR  = 3'h4;
  localparam logic [MODE_W-1:0] MODE_FIVE  = 3'h5;
  localparam logic [MODE_W-1:0] MODE_SIX   = 3'h6;
  localparam logic [DIST_W-1:0] BG_RESET   = 16'hffff;

  // Indicator colour code: two bits per indicator
  typedef enum logic [1:0] {
    DZMC_LED_OFF,
    DZMC_LED_GREEN,
    DZMC_LED_RED
  } dzmc_led_t;

  typedef enum logic [2:0] {
    DZMC_IDLE,
    DZMC_HOLD,
    DZMC_TEACH_BACKGROUND_BUTTON,
    DZMC_DELAY,
    DZMC_OPER,
    DZMC_SAMPLE
  } dzmc_state_t;
endpackage

// >>> include/dzmc_tick_if.sv
/*
  Millisecond tick carrier between the controller and its divider.
  Assumes both ends share clk.
*/
`timescale 1ns/1ps
interface dzmc_tick_if;
  logic ms_tick;
  modport source (output ms_tick);
  modport sink   (input  ms_tick);
endinterface

// >>> hw/dzmc_ms_divider.sv
/*
  Divides the system clock down to a one-cycle pulse each millisecond.
  Assumes clk at the package clock rate and active-low async reset.
*/
`timescale 1ns/1ps
module dzmc_ms_divider
  import dzmc_pkg::*;
#(
  parameter int unsigned CYCLES = MS_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   resetn,
  dzmc_tick_if.source tick
);
  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              pulse;
  } dzmc_div_t;

  dzmc_div_t s_q;
  dzmc_div_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (s_q.cnt == TICK_W'(CYCLES - 1)) begin
      s_d.cnt = '0;
      s_d.pulse = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick.ms_tick = s_q.pulse;
endmodule // dzmc_ms_divider

// >>> hw/dzmc_controller.sv
/*
  Mode and teach-in controller of a distance sensor.
  Holds the setup sequence for the threshold modes, the switching output,
  the two zone indicators and the pass-through of distance samples.
  Phases of a threshold mode: wait for a held teach button, store the
  current distance as background, wait the operation delay with dark
  indicators, then operate with green indicators, which mode one turns red while the output is on.
  Mode six skips all of this and only samples distances.
  A second long hold in operation teaches a new background.
  Zero delay or timeout settings select the built-in defaults.
  The setup timeout only bounds the operation delay, since programming
  itself takes a single cycle.
  Only the background threshold is kept; modes three to five use it as
  their one zone limit.

  Assumes inputs synchronous to clk, a distance sample marked by a
  one-cycle valid strobe, a mode selection that stays put after reset,
  and a millisecond tick from the divider inside this module.
*/
`timescale 1ns/1ps
module dzmc_controller
  import dzmc_pkg::*;
#(
  parameter int unsigned DELAY_MS_P   = DELAY_MS_DEF,
  parameter int unsigned TIMEOUT_MS_P = TIMEOUT_MS_DEF,
  parameter int unsigned HOLD_MS_P    = HOLD_MS_DEF,
  parameter int unsigned MS_CYCLES_P  = MS_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic [dzmc_pkg::MODE_W-1:0]   mode_select,
  input  wire logic                          teach_background_button,
  input  wire logic [dzmc_pkg::MS_CNT_W-1:0] operation_delay_setting,
  input  wire logic [dzmc_pkg::MS_CNT_W-1:0] setup_timeout_setting,
  input  wire logic                          dist_valid,
  input  wire logic [dzmc_pkg::DIST_W-1:0]   dist_value,
  output logic                               switch_out,
  output dzmc_pkg::dzmc_led_t                first_zone_indicator,
  output dzmc_pkg::dzmc_led_t                second_zone_indicator,
  output logic                               dist_out_valid,
  output logic [dzmc_pkg::DIST_W-1:0]        dist_out,
  output logic [dzmc_pkg::DIST_W-1:0]        background_threshold,
  output logic                               operating
);
  import dzmc_pkg::*;

  typedef struct packed {
    dzmc_state_t         st;
    logic [MODE_W-1:0]   mode;
    logic [MS_CNT_W-1:0] hold_ms;
    logic [MS_CNT_W-1:0] step_ms;
    logic [DIST_W-1:0]   bg;
    logic [DIST_W-1:0]   cur;
    logic                occ;
    logic                sw;
    dzmc_led_t           led;
    logic                dv;
    logic [DIST_W-1:0]   dout;
    logic                oper;
  } dzmc_ctl_t;

  dzmc_ctl_t   s_q;
  dzmc_ctl_t   s_d;
  dzmc_tick_if tick_if ();
  logic        in_zone;

  dzmc_ms_divider #(
    .CYCLES (MS_CYCLES_P)
  ) u_div (
    .clk    (clk),
    .resetn (resetn),
    .tick   (tick_if.source)
  );

  // Zero settings fall back to the defaults
  function automatic logic [MS_CNT_W-1:0] pick(input logic [MS_CNT_W-1:0] v,
                                               input int unsigned def);
    pick = (v == '0) ? MS_CNT_W'(def) : v;
  endfunction

  function automatic logic is_thr_mode(input logic [MODE_W-1:0] m);
    is_thr_mode = (m >= MODE_ONE) && (m <= MODE_FIVE);
  endfunction

  // Register contents right after reset
  localparam dzmc_ctl_t CTL_RESET = '{
    st:      DZMC_IDLE,
    mode:    '0,
    hold_ms: '0,
    step_ms: '0,
    bg:      BG_RESET,
    cur:     '0,
    occ:     1'b0,
    sw:      1'b0,
    led:     DZMC_LED_OFF,
    dv:      1'b0,
    dout:    '0,
    oper:    1'b0
  };

  // Button hold time in milliseconds, cleared on release, saturating
  function automatic logic [MS_CNT_W-1:0] hold_next(input logic                btn,
                                                    input logic                tick,
                                                    input logic [MS_CNT_W-1:0] cnt);
    if (!btn) begin
      hold_next = '0;
    end else if (tick && cnt != '1) begin
      hold_next = cnt + 1'b1;
    end else begin
      hold_next = cnt;
    end
  endfunction

  // Long enough hold starts teaching
  function automatic logic hold_done(input logic btn, input logic [MS_CNT_W-1:0] cnt);
    hold_done = btn && (cnt >= MS_CNT_W'(HOLD_MS_P));
  endfunction

  // Leave for programming: indicators dark, output released
  function automatic dzmc_ctl_t go_teach_background_button(input dzmc_ctl_t s);
    go_teach_background_button         = s;
    go_teach_background_button.hold_ms = '0;
    go_teach_background_button.step_ms = '0;
    go_teach_background_button.sw      = 1'b0;
    go_teach_background_button.oper    = 1'b0;
    go_teach_background_button.led     = DZMC_LED_OFF;
    go_teach_background_button.st      = DZMC_TEACH_BACKGROUND_BUTTON;
  endfunction

  // Enter operation with steady green indicators and a clear zone history
  function automatic dzmc_ctl_t go_oper(input dzmc_ctl_t s);
    go_oper      = s;
    go_oper.led  = DZMC_LED_GREEN;
    go_oper.oper = 1'b1;
    go_oper.occ  = 1'b0;
    go_oper.sw   = 1'b0;
    go_oper.st   = DZMC_OPER;
  endfunction

  // First state after reset for a latched mode
  function automatic dzmc_state_t start_state(input logic [MODE_W-1:0] m);
    case (m)
      MODE_SIX: begin
        start_state = DZMC_SAMPLE;
      end
      MODE_ONE, MODE_TWO, MODE_THREE, MODE_FOUR, MODE_FIVE: begin
        start_state = DZMC_HOLD;
      end
      default: begin
        start_state = DZMC_IDLE;
      end
    endcase
  endfunction

  // Next switching output for one new sample
  function automatic logic sw_next(input logic [MODE_W-1:0] m,
                                   input logic              was_in,
                                   input logic              now_in);
    case (m)
      MODE_ONE: begin
        sw_next = now_in;
      end
      MODE_THREE: begin
        sw_next = now_in;
      end
      MODE_TWO, MODE_FOUR, MODE_FIVE: begin
        sw_next = was_in && !now_in;
      end
      default: begin
        sw_next = 1'b0;
      end
    endcase
  endfunction

  // Mode one shows red while the output is on
  function automatic dzmc_led_t led_next(input logic [MODE_W-1:0] m,
                                         input logic              now_in,
                                         input dzmc_led_t         cur_led);
    if (m == MODE_ONE) begin
      led_next = now_in ? DZMC_LED_RED : DZMC_LED_GREEN;
    end else begin
      led_next = cur_led;
    end
  endfunction

  assign in_zone = dist_value < s_q.bg;

  always_comb begin
    s_d = s_q;
    s_d.dv = 1'b0;
    if (dist_valid) begin
      s_d.dv = 1'b1;
      s_d.dout = dist_value;
      s_d.cur = dist_value;
    end
    if (tick_if.ms_tick && s_q.step_ms != '1) begin
      s_d.step_ms = s_q.step_ms + 1'b1;
    end
    case (s_q.st)
      DZMC_IDLE: begin
        s_d.mode    = mode_select;
        s_d.step_ms = '0;
        s_d.sw      = 1'b0;
        s_d.st      = start_state(mode_select);
        s_d.led     = is_thr_mode(mode_select) ? DZMC_LED_GREEN : DZMC_LED_OFF;
      end
      DZMC_HOLD: begin
        s_d.hold_ms = hold_next(teach_background_button, tick_if.ms_tick, s_q.hold_ms);
        if (hold_done(teach_background_button, s_q.hold_ms)) begin
          s_d = go_teach_background_button(s_d);
        end
      end
      DZMC_TEACH_BACKGROUND_BUTTON: begin
        s_d.bg = s_q.cur;
        s_d.step_ms = '0;
        s_d.st = DZMC_DELAY;
      end
      DZMC_DELAY: begin
        s_d.led = DZMC_LED_OFF;
        if (s_q.step_ms >= pick(operation_delay_setting, DELAY_MS_P)) begin
          s_d = go_oper(s_d);
        end else if (s_q.step_ms >= pick(setup_timeout_setting, TIMEOUT_MS_P)) begin
          s_d = go_oper(s_d);
        end
      end
      DZMC_OPER: begin
        if (dist_valid) begin
          s_d.occ = in_zone;
          s_d.sw  = sw_next(s_q.mode, s_q.occ, in_zone);
          s_d.led = led_next(s_q.mode, in_zone, s_q.led);
        end
        // Holding the button again re-teaches the background
        s_d.hold_ms = hold_next(teach_background_button, tick_if.ms_tick, s_q.hold_ms);
        if (hold_done(teach_background_button, s_q.hold_ms)) begin
          s_d = go_teach_background_button(s_d);
        end
      end
      DZMC_SAMPLE: begin
        s_d.sw = 1'b0;
        s_d.oper = 1'b1;
      end
      default: s_d.st = DZMC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign switch_out            = s_q.sw;
  assign first_zone_indicator  = s_q.led;
  assign second_zone_indicator = s_q.led;
  assign dist_out_valid        = s_q.dv;
  assign dist_out              = s_q.dout;
  assign background_threshold  = s_q.bg;
  assign operating             = s_q.oper;
endmodule // dzmc_controller

// >>> testbench/dzmc_chk.sv
/* Port checker for the mode controller. Assumes binding to dzmc_controller. */
`timescale 1ns/1ps
module dzmc_chk
  import dzmc_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic [MODE_W-1:0]      mode_select,
  input wire logic                   dist_valid,
  input wire logic [DIST_W-1:0]      dist_value,
  input wire logic                   switch_out,
  input wire dzmc_pkg::dzmc_led_t    first_zone_indicator,
  input wire dzmc_pkg::dzmc_led_t    second_zone_indicator,
  input wire logic                   dist_out_valid,
  input wire logic [DIST_W-1:0]      dist_out,
  input wire logic [DIST_W-1:0]      background_threshold,
  input wire logic                   operating
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  dist_echo_a: assert property (dist_valid |=> dist_out_valid && dist_out == $past(dist_value))
    else $error("distance echo wrong");
  echo_only_a: assert property (!dist_valid |=> !dist_out_valid)
    else $error("spurious distance echo");
  led_pair_a: assert property (first_zone_indicator == second_zone_indicator)
    else $error("indicators differ");
  red_switch_a: assert property (first_zone_indicator == DZMC_LED_RED |-> switch_out)
    else $error("red without output");
  switch_oper_a: assert property (switch_out |-> operating)
    else $error("output before operation");
  bg_write_a: assert property ($changed(background_threshold) |-> !operating)
    else $error("background changed in operation");
  mode_one_a: assert property (mode_select == MODE_ONE && operating && dist_valid
    |=> switch_out == ($past(dist_value) < $past(background_threshold)))
    else $error("mode one output wrong");
  six_quiet_a: assert property (mode_select == MODE_SIX |-> !switch_out)
    else $error("mode six drove output");
  green_start_a: assert property ($rose(operating) && mode_select != MODE_SIX
    |-> first_zone_indicator == DZMC_LED_GREEN) else $error("not green on operation");
endmodule // dzmc_chk
bind dzmc_controller dzmc_chk u_chk (.clk(clk), .resetn(resetn), .mode_select(mode_select),
  .dist_valid(dist_valid), .dist_value(dist_value), .switch_out(switch_out),
  .first_zone_indicator(first_zone_indicator), .second_zone_indicator(second_zone_indicator),
  .dist_out_valid(dist_out_valid), .dist_out(dist_out),
  .background_threshold(background_threshold), .operating(operating));

// >>> testbench/dzmc_plc_model.sv
/* Bus master stand-in that reads each announced distance. Assumes clk shared. */
`timescale 1ns/1ps
module dzmc_plc_model
  import dzmc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              dist_out_valid,
  input  wire logic [DIST_W-1:0] dist_out,
  output logic      [DIST_W-1:0] read_dist
);
  always_ff @(posedge clk) begin
    if (dist_out_valid) begin
      read_dist <= dist_out;
    end
  end
endmodule // dzmc_plc_model

// >>> testbench/distance_zone_mode_controller_tb.sv
/* Random bench over all six modes. Assumes a 1 ms tick scaled to 10 cycles. */
`timescale 1ns/1ps
module distance_zone_mode_controller_tb;
  import dzmc_pkg::*;
  logic        clk, resetn, btn, dv, sw, ov, op, p, c;
  logic [2:0]  mode;
  logic [15:0] dly, tmo, dval, dout, bg, rd, t, v;
  dzmc_led_t   led1, led2;
  logic [31:0] lfsr_q;
  int          miscompares, samples_checked, n, e;
  dzmc_controller #(.DELAY_MS_P(10), .TIMEOUT_MS_P(50), .HOLD_MS_P(5), .MS_CYCLES_P(10)) dut (
    .clk(clk), .resetn(resetn), .mode_select(mode), .teach_background_button(btn),
    .operation_delay_setting(dly), .setup_timeout_setting(tmo), .dist_valid(dv),
    .dist_value(dval), .switch_out(sw), .first_zone_indicator(led1),
    .second_zone_indicator(led2), .dist_out_valid(ov), .dist_out(dout),
    .background_threshold(bg), .operating(op));
  dzmc_plc_model plc (.clk(clk), .dist_out_valid(ov), .dist_out(dout), .read_dist(rd));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function automatic logic exp_sw(input logic [2:0] m, input logic pv, input logic cv);
    if (m == MODE_ONE || m == MODE_THREE) return cv;
    return (m == MODE_SIX) ? 1'b0 : (pv && !cv);
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic sample(input logic [15:0] x);
    @(negedge clk);
    dv = 1;
    dval = x;
    @(negedge clk);
    dv = 0;
  endtask
  initial begin
    lfsr_q = 32'hb588caa5;
    btn = 0; dv = 0; dval = 0; dly = 16'h8; tmo = 16'h28; resetn = 0; mode = 1;
    for (int m = 1; m <= 6; m++) begin
      mode = 3'(m);
      tmo = (m == 4) ? 16'h3 : 16'h28;
      resetn = 0;
      repeat (12) @(negedge clk);
      resetn = 1;
      repeat (3) @(negedge clk);
      if (m == 6) begin
        chk(16'(op), 16'h1);
      end else begin
        chk(16'(led1), 16'(DZMC_LED_GREEN));
        lfsr_q = lfsr_next(lfsr_q);
        t = {4'h7, lfsr_q[11:0]};
        sample(t);
        btn = 1;
        n = 0;
        while (led1 !== DZMC_LED_OFF && n < 200) begin
          @(negedge clk);
          n++;
        end
        btn = 0;
        if (n >= 200) begin
          miscompares++;
          summarize();
        end
        chk(16'(n >= 40 && n <= 60), 16'h1);
        e = (m == 4) ? 30 : 80;
        n = 0;
        while (op !== 1'b1 && n < 1000) begin
          @(negedge clk);
          n++;
          if (op !== 1'b1) chk(16'({led1, led2, sw}), 16'h0);
        end
        if (n >= 1000) begin
          miscompares++;
          summarize();
        end
        chk(16'(n >= e - 10 && n <= e + 10), 16'h1);
        chk(16'(led1), 16'(DZMC_LED_GREEN));
        chk(bg, t);
      end
      p = 0;
      for (int k = 0; k < 24; k++) begin
        lfsr_q = lfsr_next(lfsr_q);
        v = (k == 0 || k == 5) ? t : lfsr_q[15:0];
        sample(v);
        c = (m != 6) && (v < t);
        chk(16'(sw), 16'(exp_sw(3'(m), p, c)));
        if (m == 1) chk(16'(led1), 16'(c ? DZMC_LED_RED : DZMC_LED_GREEN));
        @(negedge clk);
        chk(rd, v);
        p = c;
      end
      $display("mode %0d done", m);
    end
    summarize();
  end
endmodule // distance_zone_mode_controller_tb
